// ### rtl/smp_port.sv
// Byte-wide serial port, master or slave, with register access
`default_nettype none
// Contract
// - Slave: select high resets send/receive logic, drops partial byte.
// - Slave with select high stays passive, accepts no data, drives nothing.
// - Master with select as output: select pin is plain general output.
// - Master, select input low clears master bit; becomes slave.
// - That forced drop also sets the done flag; software re-sets master.
// - Polarity and phase pick four modes; shift on opposite edge to sample.
// - Polarity bit sets SCK idle level.
// - Phase zero samples leading edge; phase one samples trailing edge.
// - Bit order one sends LSB first, zero MSB first.
// - No serial operation unless enable bit is set.
// - Interrupt when done flag, interrupt enable and global enable all set.
// - Normal rate divides clock by 4, 16, 64 or 128.
// - Double rate divides by 2, 8, 32 or 64 in master mode.
// - Rate bits have no effect in slave mode.
// - Done flag set after every completed byte.
// - Done flag cleared when its interrupt vector executes.
// - Status read with done set, then data access, clears done.
// - Data write during transfer sets collision flag; in slave mode only once the bit counter is non-zero.
// - Status read with collision set, then data access, clears both flags.
// - Status bits 5 to 1 read zero.
// - Data write starts transfer; data read returns receive buffer.
// - Transmit single buffered, receive double buffered, overwrite if unread.
// - Master: data write starts clock, eight bits shift, clock stops.
module smp_port (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Interrupt
  input wire logic global_irq_en,
  input wire logic irq_ack,
  output logic irq,
  // Select pin direction and general output
  input wire logic sel_is_output,
  input wire logic sel_gpo,
  // Serial pins
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  input wire logic sel_n_in,
  output logic sel_n_out,
  output logic sel_n_oe
);
  smp_pkg::smp_ctrl_t ctrl_reg;
  smp_pkg::smp_state_t state_reg;
  logic dbl_reg;
  logic done_reg;
  logic write_collision_flag_reg;
  logic armed_reg;
  logic [7:0] shift_reg;
  logic [7:0] rxbuf_reg;
  logic [2:0] bit_reg;
  logic [6:0] div_reg;
  logic sck_reg;
  logic sck_s1_reg;
  logic sck_s2_reg;
  logic sck_s3_reg;
  logic in_bit_reg;
  logic [7:0] rdata_reg;

  logic master;
  logic slave_act;
  logic forced_slave;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_data;
  logic rd_stat;
  logic rd_data;
  logic busy;
  logic tick;
  logic [6:0] half;
  logic m_lead;
  logic m_trail;
  logic s_edge;
  logic s_lead;
  logic s_trail;
  logic sample;
  logic setup;
  logic byte_done;
  logic serial_in;
  logic out_bit;

  function automatic logic [6:0] half_period(input logic dbl, input logic [1:0] rate);
    logic [6:0] h;
    h = smp_pkg::HALF_4;
    unique case ({dbl, rate})
      3'b000: h = smp_pkg::HALF_4;
      3'b001: h = smp_pkg::HALF_16;
      3'b010: h = smp_pkg::HALF_64;
      3'b011: h = smp_pkg::HALF_128;
      3'b100: h = smp_pkg::HALF_2;
      3'b101: h = smp_pkg::HALF_8;
      3'b110: h = smp_pkg::HALF_32;
      3'b111: h = smp_pkg::HALF_64;
    endcase
    return h;
  endfunction

  assign wr_ctrl = wr && addr == smp_pkg::CTRL_ADDR;
  assign wr_stat = wr && addr == smp_pkg::STAT_ADDR;
  assign wr_data = wr && addr == smp_pkg::DATA_ADDR;
  assign rd_stat = rd && addr == smp_pkg::STAT_ADDR;
  assign rd_data = rd && addr == smp_pkg::DATA_ADDR;

  assign master = ctrl_reg.port_en && ctrl_reg.master;
  assign forced_slave = master && !sel_is_output && !sel_n_in;
  assign slave_act = ctrl_reg.port_en && !ctrl_reg.master && !sel_n_in;
  assign busy = state_reg != smp_pkg::ST_IDLE;
  assign half = half_period(dbl_reg, ctrl_reg.rate);
  assign tick = master && busy && div_reg == half - 7'h01;

  // Master edges from the divider; slave edges from synchronised SCK
  assign m_lead = tick && state_reg == smp_pkg::ST_LEAD;
  assign m_trail = tick && state_reg == smp_pkg::ST_TRAIL;
  assign s_edge = slave_act && (sck_s2_reg != sck_s3_reg);
  assign s_lead = s_edge && (sck_s2_reg != ctrl_reg.clock_polarity);
  assign s_trail = s_edge && (sck_s2_reg == ctrl_reg.clock_polarity);
  assign sample = ctrl_reg.clock_phase ? (m_trail || s_trail) : (m_lead || s_lead);
  assign setup = ctrl_reg.clock_phase ? (m_lead || s_lead) : (m_trail || s_trail);
  assign byte_done = (m_trail || s_trail) && bit_reg == smp_pkg::LAST_BIT;
  assign serial_in = master ? miso_in : mosi_in;
  assign out_bit = ctrl_reg.lsb_first ? shift_reg[0] : shift_reg[7];

  // Control register, master bit dropped by a low select input
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= smp_pkg::CTRL_RESET;
    end else if (forced_slave) begin
      ctrl_reg.master <= 1'b0;
    end else if (wr_ctrl) begin
      ctrl_reg <= wdata;
    end
  end

  // Double rate bit
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dbl_reg <= 1'b0;
    end else if (wr_stat) begin
      dbl_reg <= wdata[smp_pkg::STAT_DBL];
    end
  end

  // Status read arms the flag clear on the next data access
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      armed_reg <= 1'b0;
    end else if (rd_stat) begin
      armed_reg <= done_reg || write_collision_flag_reg;
    end else if (rd_data || wr_data) begin
      armed_reg <= 1'b0;
    end
  end

  // Done flag; a set wins over a clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      done_reg <= 1'b0;
    end else if (byte_done || forced_slave) begin
      done_reg <= 1'b1;
    end else if (irq_ack || (armed_reg && (rd_data || wr_data))) begin
      done_reg <= 1'b0;
    end
  end

  // Collision flag
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      write_collision_flag_reg <= 1'b0;
    end else if (wr_data && (busy || (slave_act && bit_reg != 3'h0))) begin
      write_collision_flag_reg <= 1'b1;
    end else if (armed_reg && (rd_data || wr_data)) begin
      write_collision_flag_reg <= 1'b0;
    end
  end

  assign irq = done_reg && ctrl_reg.irq_en && global_irq_en;

  // SCK synchroniser and edge history for slave mode
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sck_s1_reg <= 1'b0;
      sck_s2_reg <= 1'b0;
      sck_s3_reg <= 1'b0;
    end else begin
      sck_s1_reg <= sck_in;
      sck_s2_reg <= sck_s1_reg;
      sck_s3_reg <= sck_s2_reg;
    end
  end

  // Master sequencer: idle, leading half, trailing half
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= smp_pkg::ST_IDLE;
      div_reg <= 7'h00;
    end else if (!master) begin
      state_reg <= smp_pkg::ST_IDLE;
      div_reg <= 7'h00;
    end else begin
      div_reg <= tick || !busy ? 7'h00 : div_reg + 7'h01;
      unique case (state_reg)
        smp_pkg::ST_IDLE: if (wr_data) state_reg <= smp_pkg::ST_LEAD;
        smp_pkg::ST_LEAD: if (tick) state_reg <= smp_pkg::ST_TRAIL;
        smp_pkg::ST_TRAIL: begin
          if (tick) begin
            state_reg <= bit_reg == smp_pkg::LAST_BIT ? smp_pkg::ST_IDLE
                                                      : smp_pkg::ST_LEAD;
          end
        end
        default: state_reg <= smp_pkg::ST_IDLE;
      endcase
    end
  end

  // SCK level driven in master mode
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sck_reg <= 1'b0;
    end else if (!busy) begin
      sck_reg <= ctrl_reg.clock_polarity;
    end else if (tick) begin
      sck_reg <= !sck_reg;
    end
  end

  // Shift register, bit counter and sampled input bit
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shift_reg <= smp_pkg::DATA_RESET;
      bit_reg <= 3'h0;
      in_bit_reg <= 1'b0;
    end else if (!ctrl_reg.port_en) begin
      bit_reg <= 3'h0;
    end else if (!master && sel_n_in) begin
      bit_reg <= 3'h0;
      if (wr_data) shift_reg <= wdata;
    end else if (wr_data && !busy && bit_reg == 3'h0) begin
      shift_reg <= wdata;
    end else begin
      if (sample) in_bit_reg <= serial_in;
      if (setup && !(ctrl_reg.clock_phase && bit_reg == 3'h0)) begin
        shift_reg <= ctrl_reg.lsb_first ? {in_bit_reg, shift_reg[7:1]}
                                        : {shift_reg[6:0], in_bit_reg};
      end
      if (m_trail || s_trail) bit_reg <= bit_reg + 3'h1;
    end
  end

  // Receive buffer, overwritten by each finished byte
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rxbuf_reg <= smp_pkg::DATA_RESET;
    end else if (byte_done) begin
      if (ctrl_reg.clock_phase) begin
        rxbuf_reg <= ctrl_reg.lsb_first ? {serial_in, shift_reg[7:1]}
                                        : {shift_reg[6:0], serial_in};
      end else begin
        rxbuf_reg <= ctrl_reg.lsb_first ? {in_bit_reg, shift_reg[7:1]}
                                        : {shift_reg[6:0], in_bit_reg};
      end
    end
  end

  // Read data one cycle after the strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= 8'h00;
    end else if (rd) begin
      unique case (addr)
        smp_pkg::CTRL_ADDR: rdata_reg <= ctrl_reg;
        smp_pkg::STAT_ADDR: rdata_reg <= {done_reg, write_collision_flag_reg, 5'h00, dbl_reg};
        smp_pkg::DATA_ADDR: rdata_reg <= rxbuf_reg;
        default: rdata_reg <= 8'h00;
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end
  assign rdata = rdata_reg;

  // Pin drive
  assign sck_out = sck_reg;
  assign sck_oe = master;
  assign mosi_out = out_bit;
  assign mosi_oe = master;
  assign miso_out = out_bit;
  assign miso_oe = slave_act;
  assign sel_n_out = sel_gpo;
  assign sel_n_oe = ctrl_reg.master && sel_is_output;
endmodule
`default_nettype wire

// ### rtl/smp_pkg.sv
// Package with register map, field positions and timing constants of the serial port
`default_nettype none
package smp_pkg;
  // Register byte addresses
  localparam logic [7:0] CTRL_ADDR = 8'h2C;
  localparam logic [7:0] STAT_ADDR = 8'h2D;
  localparam logic [7:0] DATA_ADDR = 8'h2E;
  // Control field positions
  localparam int CTRL_IRQ_EN = 7;
  localparam int CTRL_PORT_EN = 6;
  localparam int CTRL_LSB_FIRST = 5;
  localparam int CTRL_MASTER = 4;
  localparam int CTRL_CLOCK_POLARITY = 3;
  localparam int CTRL_CLOCK_PHASE = 2;
  // Status field positions
  localparam int STAT_DONE = 7;
  localparam int STAT_WRITE_COLLISION_FLAG = 6;
  localparam int STAT_DBL = 0;
  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  // Index of the last bit in a byte
  localparam logic [2:0] LAST_BIT = 3'h7;
  // Half period of SCK in system clocks, per rate code {double, hi, lo}
  localparam logic [6:0] HALF_4 = 7'h02;
  localparam logic [6:0] HALF_16 = 7'h08;
  localparam logic [6:0] HALF_64 = 7'h20;
  localparam logic [6:0] HALF_128 = 7'h40;
  localparam logic [6:0] HALF_2 = 7'h01;
  localparam logic [6:0] HALF_8 = 7'h04;
  localparam logic [6:0] HALF_32 = 7'h10;

  typedef struct packed {
    logic irq_en;
    logic port_en;
    logic lsb_first;
    logic master;
    logic clock_polarity;
    logic clock_phase;
    logic [1:0] rate;
  } smp_ctrl_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LEAD = 3'b010,
    ST_TRAIL = 3'b100
  } smp_state_t;
endpackage
`default_nettype wire

// ### tb/smp_port_assertions.sv
// Checker of register port, select and serial pin behaviour
`default_nettype none
module smp_port_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire logic [7:0] addr,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  // Interrupt
  input wire logic global_irq_en,
  input wire logic irq,
  // Pins
  input wire logic sel_is_output,
  input wire logic sel_n_in,
  input wire logic sck_out,
  input wire logic sck_oe,
  input wire logic mosi_oe,
  input wire logic miso_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sck_q;
  logic [4:0] tgl;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // SCK toggles since last data or control write
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sck_q <= 1'b0;
      tgl <= 5'h00;
    end else begin
      sck_q <= sck_out;
      if (wr && (addr == smp_pkg::DATA_ADDR || addr == smp_pkg::CTRL_ADDR)) tgl <= 5'h00;
      else if (sck_oe && sck_out != sck_q && tgl != 5'h1F) tgl <= tgl + 5'h01;
    end
  end
  sequence s_low_held;
    (!sel_is_output && !sel_n_in) [*6];
  endsequence
  sequence s_high_held;
    sel_n_in [*6];
  endsequence
  AST_RDATA_IDLE: assert property (!rd |=> rdata == 8'h00)
    else $error("read data not zero outside answer");
  AST_STAT_RSVD: assert property (rd && addr == smp_pkg::STAT_ADDR |=> rdata[5:1] == 5'h00)
    else $error("status reserved bits not zero");
  AST_IRQ_GATE: assert property (!global_irq_en |-> !irq)
    else $error("irq without global enable");
  AST_PASSIVE: assert property (s_high_held |-> !miso_oe)
    else $error("miso driven while deselected");
  AST_RELEASE: assert property ($rose(sel_n_in) |-> ##[0:6] !miso_oe)
    else $error("miso not released after select rise");
  AST_ROLE: assert property (sck_oe |-> !miso_oe)
    else $error("sck and miso driven together");
  AST_DROP: assert property (s_low_held |-> !sck_oe && !mosi_oe)
    else $error("still driving after select low");
  AST_EIGHT: assert property (tgl <= 5'h10)
    else $error("more than eight clock pulses");
endmodule
bind smp_port smp_port_assertions i_chk (.*);
`default_nettype wire

// ### tb/smp_slave_model.sv
// Behavioural slave on the far side of the serial pins
`default_nettype none
module smp_slave_model (
  // Serial pins
  input wire logic sck,
  input wire logic sel_n,
  input wire logic mosi,
  output logic miso,
  // Mode and data
  input wire logic clock_polarity,
  input wire logic clock_phase,
  input wire logic [7:0] tx,
  output logic [7:0] rx
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sr = 8'h00;
  logic bit_q = 1'b0;
  // Released line shows inverse of last bit
  assign miso = sel_n ? ~bit_q : bit_q;
  assign rx = sr;
  always @(negedge sel_n) begin
    sr = tx;
    bit_q = tx[7];
  end
  always @(sck) begin
    if (!sel_n && sck == (clock_polarity == clock_phase)) sr = {sr[6:0], mosi};
    else if (!sel_n) bit_q = sr[7];
  end
endmodule
`default_nettype wire

// ### tb/test_spi_master_slave_port.sv
// Self-checking bench of the serial port against a slave model
`default_nettype none
module test_spi_master_slave_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, rd_q = 1'b0, irq_ack = 1'b0;
  logic global_irq_en = 1'b0, sel_is_output = 1'b1, sel_gpo = 1'b1, tb_sel = 1'b1;
  logic clock_polarity = 1'b0, clock_phase = 1'b0, lsb = 1'b0, dbl = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, tx, mtx = 8'h00, ctrl;
  logic [15:0] act = 16'h0000;
  logic tb_sck = 1'b1, tb_mosi = 1'b0;
  logic [7:0] stx, srx, got;
  logic [7:0] expq [$];
  wire logic [7:0] rdata, mrx;
  wire logic irq, sck_in, sck_out, sck_oe, mosi_in, mosi_out, mosi_oe, m_miso;
  wire logic miso_in, miso_out, miso_oe, sel_n_in, sel_n_out, sel_n_oe;
  int seed = 78108, mismatches = 0, comparisons = 0, cyc = 0, n;
  localparam int HALF [8] = '{2, 8, 32, 64, 1, 4, 16, 32};
  assign sck_in = sck_oe ? sck_out : tb_sck;
  assign mosi_in = mosi_oe ? mosi_out : tb_mosi;
  assign miso_in = miso_oe ? miso_out : m_miso;
  assign sel_n_in = sel_n_oe ? sel_n_out : tb_sel;
  always #4 clk = ~clk;
  smp_port i_dut (.*);
  smp_slave_model i_slv (.sck(sck_in), .sel_n(sel_n_in), .mosi(mosi_in), .miso(m_miso),
    .clock_polarity(clock_polarity), .clock_phase(clock_phase), .tx(mtx), .rx(mrx));
  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int k = 0; k < 8; k++) rev[k] = v[7 - k];
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    expq.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  // External master: mode 0, MSB first, four system clocks per SCK half
  task automatic slave_bits(input logic [7:0] d, input int nb, output logic [7:0] g);
    g = 8'h00;
    for (int k = 7; k > 7 - nb; k--) begin
      tb_mosi <= d[k];
      repeat (4) @(posedge clk);
      g[k] = miso_out;
      tb_sck <= 1'b1;
      repeat (4) @(posedge clk);
      tb_sck <= 1'b0;
    end
  endtask
  // Read answers, active SCK time, timeout
  always @(posedge clk) begin
    rd_q <= rd;
    act <= sel_gpo ? 16'h0000 : act + 16'(sck_out !== clock_polarity);
    cyc++;
    if (rd_q) chk({8'h00, rdata}, {8'h00, expq.pop_front()});
    if (cyc == 20000) begin
      mismatches++;
      finish_test();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd_reg(smp_pkg::CTRL_ADDR, smp_pkg::CTRL_RESET);
    rd_reg(smp_pkg::STAT_ADDR, 8'h00);
    rd_reg(smp_pkg::DATA_ADDR, smp_pkg::DATA_RESET);
    rd_reg(8'h00, 8'h00);
    wr_reg(8'h00, 8'hFF);
    $display("test registers done");
    global_irq_en <= 1'b1;
    wr_reg(smp_pkg::CTRL_ADDR, 8'h90);
    wr_reg(smp_pkg::DATA_ADDR, 8'hA5);
    repeat (100) @(posedge clk);
    chk({15'h0000, irq}, 16'h0000);
    rd_reg(smp_pkg::STAT_ADDR, 8'h00);
    $display("test disabled port done");
    for (int i = 0; i < 8; i++) begin
      {dbl, clock_phase, clock_polarity} = 3'(i);
      lsb = clock_polarity ^ dbl;
      ctrl = {2'b11, lsb, 1'b1, clock_polarity, clock_phase, clock_phase, clock_polarity};
      wr_reg(smp_pkg::CTRL_ADDR, ctrl);
      wr_reg(smp_pkg::STAT_ADDR, {7'h00, dbl});
      tx = 8'($random(seed));
      mtx = 8'($random(seed));
      sel_gpo <= 1'b0;
      repeat (4) @(posedge clk);
      wr_reg(smp_pkg::DATA_ADDR, tx);
      if (i == 3) wr_reg(smp_pkg::DATA_ADDR, ~tx);
      n = 0;
      while (irq !== 1'b1 && n < 3000) begin
        @(posedge clk);
        n++;
      end
      @(posedge clk);
      sel_gpo <= 1'b1;
      chk(act, 16'(8 * HALF[i]));
      chk({8'h00, mrx}, {8'h00, lsb ? rev(tx) : tx});
      rd_reg(smp_pkg::STAT_ADDR, {1'b1, i == 3, 5'h00, dbl});
      rd_reg(smp_pkg::DATA_ADDR, lsb ? rev(mtx) : mtx);
      @(posedge clk);
      chk({15'h0000, irq}, 16'h0000);
      rd_reg(smp_pkg::STAT_ADDR, {7'h00, dbl});
    end
    $display("test transfers done");
    @(posedge clk);
    sel_is_output <= 1'b0;
    tb_sel <= 1'b0;
    repeat (8) @(posedge clk);
    tb_sel <= 1'b1;
    repeat (2) @(posedge clk);
    chk({15'h0000, irq}, 16'h0001);
    rd_reg(smp_pkg::CTRL_ADDR, ctrl & 8'hEF);
    @(posedge clk);
    irq_ack <= 1'b1;
    @(posedge clk);
    irq_ack <= 1'b0;
    @(posedge clk);
    chk({15'h0000, irq}, 16'h0000);
    rd_reg(smp_pkg::STAT_ADDR, {7'h00, dbl});
    $display("test forced drop done");
    tb_sck <= 1'b0;
    wr_reg(smp_pkg::CTRL_ADDR, 8'hC3);
    repeat (4) @(posedge clk);
    stx = 8'($random(seed));
    srx = 8'($random(seed));
    tb_sel <= 1'b0;
    slave_bits(~srx, 3, got);
    tb_sel <= 1'b1;
    repeat (4) @(posedge clk);
    chk({15'h0000, miso_oe}, 16'h0000);
    wr_reg(smp_pkg::DATA_ADDR, stx);
    tb_sel <= 1'b0;
    slave_bits(srx, 8, got);
    repeat (6) @(posedge clk);
    chk({8'h00, got}, {8'h00, stx});
    chk({15'h0000, irq}, 16'h0001);
    rd_reg(smp_pkg::STAT_ADDR, {1'b1, 6'h00, dbl});
    rd_reg(smp_pkg::DATA_ADDR, srx);
    tb_sel <= 1'b1;
    @(posedge clk);
    chk({15'h0000, irq}, 16'h0000);
    $display("test slave done");
    finish_test();
  end
endmodule
`default_nettype wire
